// ===== hdl/kpil_pkg.sv
package kpil_pkg;

    // Pin count
    localparam int PIN_COUNT = 5;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_PIN_ENABLE = 8'h04;
    localparam logic [7:0] OFS_PIN_POLARITY = 8'h08;
    localparam logic [7:0] OFS_PORT_DATA = 8'h0C;
    localparam logic [7:0] OFS_PORT_DIR = 8'h10;
    localparam int ADDR_DECODE_W = 8;

    // Status and control field positions
    localparam int BIT_SENSITIVITY = 0;
    localparam int BIT_REQUEST_MASK = 1;
    localparam int BIT_LATCH_ACK = 2;
    localparam int BIT_PENDING = 3;

    // Reset values
    localparam logic RST_SENSITIVITY = 1'b0;
    localparam logic RST_REQUEST_MASK = 1'b0;
    localparam logic RST_LATCH = 1'b0;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

// ===== hdl/kpil_pin_sync.sv
`timescale 1ns/1ps

module kpil_pin_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pin levels
    input wire logic [WIDTH-1:0] pinAsync,
    output logic [WIDTH-1:0] pinSync
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } kpil_sync_s;

    kpil_sync_s s_q;
    kpil_sync_s s_d;

    // First stage feeds only the second; nothing else looks at it
    always_comb
    begin
        s_d = s_q;
        s_d.stage1 = pinAsync;
        s_d.stage2 = s_q.stage1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pinSync = s_q.stage2;

endmodule // kpil_pin_sync

// ===== hdl/kpil_top.sv
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps


module kpil_top #(
    parameter int NPINS = kpil_pkg::PIN_COUNT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Port pins, two-way
    input wire logic [NPINS-1:0] pinIn,
    output logic [NPINS-1:0] pinOut,
    output logic [NPINS-1:0] pinOe,
    // Pull devices
    output logic [NPINS-1:0] pullUpEn,
    output logic [NPINS-1:0] pullDownEn,
    // CPU interrupt logic
    input wire logic vectorFetchAck,
    output logic irqRequest,
    output logic pendingFlag
);

    typedef struct packed {
        logic [NPINS-1:0] pinIrqEnable;
        logic [NPINS-1:0] pinPolaritySelect;
        logic [NPINS-1:0] portData;
        logic [NPINS-1:0] portDir;
        logic [NPINS-1:0] prevActive;
        logic sensitivitySelect;
        logic requestMask;
        logic latch;
        logic ackSeen;
        logic wrPend;
        logic [kpil_pkg::ADDR_DECODE_W-1:0] wrAddr;
        logic [31:0] rdata;
    } kpil_state_s;

    kpil_state_s s_q;
    kpil_state_s s_d;

    logic [NPINS-1:0] pinLevel;
    logic [NPINS-1:0] levelActive;
    logic [NPINS-1:0] asserted;
    logic [NPINS-1:0] edges;
    logic addrPhase;
    logic [kpil_pkg::ADDR_DECODE_W-1:0] rdAddr;
    logic swAck;
    logic ackPulse;
    logic anyAsserted;
    logic edgeSet;
    logic setLatch;
    logic clearLatch;

    kpil_pin_sync #(
        .WIDTH(NPINS)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .pinAsync(pinIn),
        .pinSync(pinLevel)
    );

    // Zero wait states keep the master simple; every access is a single word
    assign addrPhase = hsel & hready & htrans[1];
    assign rdAddr = haddr[kpil_pkg::ADDR_DECODE_W-1:0];

    // Polarity decides which level counts as active
    assign levelActive = ~(pinLevel ^ s_q.pinPolaritySelect);
    assign asserted = levelActive & s_q.pinIrqEnable;
    assign edges = asserted & ~s_q.prevActive;
    assign anyAsserted = |asserted;

    // A pin already held asserted masks new edges on other pins
    assign edgeSet = (|edges) & ~(|(asserted & s_q.prevActive));

    assign swAck = s_q.wrPend
        & (s_q.wrAddr == kpil_pkg::OFS_STATUS_CONTROL)
        & hwdata[kpil_pkg::BIT_LATCH_ACK];
    assign ackPulse = vectorFetchAck | swAck;

    always_comb
    begin
        s_d = s_q;
        setLatch = 1'b0;
        clearLatch = 1'b0;

        // Register writes land in the data phase
        if (s_q.wrPend)
        begin
            case (s_q.wrAddr)
                kpil_pkg::OFS_STATUS_CONTROL:
                begin
                    s_d.sensitivitySelect = hwdata[kpil_pkg::BIT_SENSITIVITY];
                    s_d.requestMask = hwdata[kpil_pkg::BIT_REQUEST_MASK];
                end
                kpil_pkg::OFS_PIN_ENABLE:
                begin
                    s_d.pinIrqEnable = hwdata[NPINS-1:0];
                end
                kpil_pkg::OFS_PIN_POLARITY:
                begin
                    s_d.pinPolaritySelect = hwdata[NPINS-1:0];
                end
                kpil_pkg::OFS_PORT_DATA:
                begin
                    s_d.portData = hwdata[NPINS-1:0];
                end
                kpil_pkg::OFS_PORT_DIR:
                begin
                    s_d.portDir = hwdata[NPINS-1:0];
                end
                default:
                begin
                    // Unmapped writes are dropped
                    s_d.portDir = s_q.portDir;
                end
            endcase
        end

        s_d.prevActive = levelActive;

        // Latch update; a set in the same cycle as a clear wins
        if (s_q.sensitivitySelect)
        begin
            setLatch = anyAsserted;
            clearLatch = (ackPulse | s_q.ackSeen) & ~anyAsserted;
        end
        else
        begin
            setLatch = edgeSet;
            clearLatch = ackPulse;
        end
        s_d.latch = setLatch | (s_q.latch & ~clearLatch);

        // Remember an early acknowledge until the pins let go
        s_d.ackSeen = s_q.sensitivitySelect & s_d.latch & ~(|edges)
            & (s_q.ackSeen | ackPulse);

        // Capture the address phase
        s_d.wrPend = addrPhase & hwrite;
        s_d.wrAddr = addrPhase ? rdAddr : s_q.wrAddr;

        // Read data is taken from the next state so a read right after a write sees it
        if (addrPhase & ~hwrite)
        begin
            s_d.rdata = 32'h0000_0000;
            case (rdAddr)
                kpil_pkg::OFS_STATUS_CONTROL:
                begin
                    s_d.rdata[kpil_pkg::BIT_SENSITIVITY] = s_d.sensitivitySelect;
                    s_d.rdata[kpil_pkg::BIT_REQUEST_MASK] = s_d.requestMask;
                    s_d.rdata[kpil_pkg::BIT_LATCH_ACK] = 1'b0;
                    s_d.rdata[kpil_pkg::BIT_PENDING] = s_d.latch;
                end
                kpil_pkg::OFS_PIN_ENABLE:
                begin
                    s_d.rdata[NPINS-1:0] = s_d.pinIrqEnable;
                end
                kpil_pkg::OFS_PIN_POLARITY:
                begin
                    s_d.rdata[NPINS-1:0] = s_d.pinPolaritySelect;
                end
                kpil_pkg::OFS_PORT_DATA:
                begin
                    // Pin level shows only where the direction bit is 0
                    s_d.rdata[NPINS-1:0] = (pinLevel & ~s_d.portDir)
                        | (s_d.portData & s_d.portDir);
                end
                kpil_pkg::OFS_PORT_DIR:
                begin
                    s_d.rdata[NPINS-1:0] = s_d.portDir;
                end
                default:
                begin
                    s_d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
            s_q.sensitivitySelect <= kpil_pkg::RST_SENSITIVITY;
            s_q.requestMask <= kpil_pkg::RST_REQUEST_MASK;
            s_q.latch <= kpil_pkg::RST_LATCH;
            s_q.pinPolaritySelect <= '0;
            s_q.rdata <= kpil_pkg::RST_RDATA;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Bus answer
    assign hreadyout = 1'b1;
    assign hresp = kpil_pkg::HRESP_OKAY;
    assign hrdata = s_q.rdata;

    // An enabled pin is always an input, whatever its direction bit says
    assign pinOut = s_q.portData;
    assign pinOe = s_q.portDir & ~s_q.pinIrqEnable;

    // Pull toward the inactive level
    assign pullUpEn = s_q.pinIrqEnable & ~s_q.pinPolaritySelect;
    assign pullDownEn = s_q.pinIrqEnable & s_q.pinPolaritySelect;

    assign pendingFlag = s_q.latch;
    assign irqRequest = s_q.latch & ~s_q.requestMask;

endmodule // kpil_top

// ===== tb/kpil_top_assertions.sv
`timescale 1ns/1ps

module kpil_top_assertions #(
    parameter int NPINS = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins and request
    input wire logic [NPINS-1:0] pinOe,
    input wire logic [NPINS-1:0] pullUpEn,
    input wire logic [NPINS-1:0] pullDownEn,
    input wire logic irqRequest,
    input wire logic pendingFlag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    chk_pull_excl: assert property ((pullUpEn & pullDownEn) == '0)
        else $error("pullup and pulldown on together");
    chk_drive_off: assert property ((pinOe & (pullUpEn | pullDownEn)) == '0)
        else $error("enabled pin still driven");
    chk_irq_pend: assert property (irqRequest |-> pendingFlag)
        else $error("request without pending flag");
    chk_set_cause: assert property ($rose(pendingFlag) |-> $past(pullUpEn | pullDownEn) != '0)
        else $error("latch set with no enabled pin");
    chk_bus_okay: assert property (hreadyout && hresp == kpil_pkg::HRESP_OKAY)
        else $error("bus stalled or error response");
    chk_reset_clear: assert property ($rose(resetn) |-> !pendingFlag && pullUpEn == '0)
        else $error("state left after reset");
    chk_pull_write: assert property ($changed(pullUpEn | pullDownEn) |->
        $past(hsel && htrans[1] && hwrite, 2))
        else $error("pull changed without a write");
    chk_oe_write: assert property ($changed(pinOe) |-> $past(hsel && htrans[1] && hwrite, 2))
        else $error("drive changed without a write");
endmodule // kpil_top_assertions

bind kpil_top kpil_top_assertions #(.NPINS(NPINS)) chk_u (.clk, .resetn, .hsel, .htrans,
    .hwrite, .hreadyout, .hresp, .pinOe, .pullUpEn, .pullDownEn, .irqRequest, .pendingFlag);

// ===== tb/kpil_keypad_model.sv
`timescale 1ns/1ps

module kpil_keypad_model #(
    parameter int N = 5
) (
    // Bench side
    input wire logic clk,
    input wire logic [N-1:0] keyDown,
    input wire logic [N-1:0] keyLvl,
    // Device side
    input wire logic [N-1:0] pinOut,
    input wire logic [N-1:0] pinOe,
    input wire logic [N-1:0] pullUpEn,
    input wire logic [N-1:0] pullDownEn,
    output logic [N-1:0] pinLevel
);
    logic [N-1:0] lastQ = '0;
    always_ff @(posedge clk)
        lastQ <= pinLevel;
    // A floating line flips each cycle so that no stale level is trusted
    always_comb
        for (int i = 0; i < N; i++)
            pinLevel[i] = pinOe[i] ? pinOut[i] : keyDown[i] ? keyLvl[i] :
                pullUpEn[i] | (~pullDownEn[i] & ~lastQ[i]);
endmodule // kpil_keypad_model

// ===== tb/keypad_pin_interrupt_latch_test.sv
`timescale 1ns/1ps

module keypad_pin_interrupt_latch_test;
    localparam logic [7:0] SC = kpil_pkg::OFS_STATUS_CONTROL;
    logic clk = 0;
    logic resetn = 0;
    logic hsel = 0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 0;
    logic [31:0] hwdata = '0;
    logic vectorFetchAck = 0;
    logic [4:0] keyDown = '0;
    logic [4:0] keyLvl = '0;
    logic hreadyout, hresp, irqRequest, pendingFlag, m, p;
    logic [31:0] hrdata;
    logic [4:0] pinIn, pinOut, pinOe, pullUpEn, pullDownEn;
    // Columns: mode, polarity, pending after acknowledge while held
    logic [2:0] rows [4] = '{3'b000, 3'b010, 3'b101, 3'b111};
    int numErrors = 0;
    int compares = 0;
    int cyc = 0;
    always #12.5 clk = ~clk;

    kpil_top dut_u (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pinIn, .pinOut, .pinOe, .pullUpEn,
        .pullDownEn, .vectorFetchAck, .irqRequest, .pendingFlag);
    kpil_keypad_model kp_u (.clk, .keyDown, .keyLvl, .pinOut, .pinOe, .pullUpEn, .pullDownEn,
        .pinLevel(pinIn));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", n, e, g);
            numErrors++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= kpil_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do tick(1); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do tick(1); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
        tick(1);
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(n, e, r);
    endtask
    task automatic setup(input logic md, input logic [4:0] pol, input logic [4:0] en);
        wr(SC, 32'h2);
        wr(kpil_pkg::OFS_PIN_POLARITY, {27'h0, pol});
        wr(kpil_pkg::OFS_PIN_ENABLE, {27'h0, en});
        tick(4);
        wr(SC, {29'h0, 2'h3, md});
        wr(SC, {31'h0, md});
    endtask
    task automatic push(input logic [4:0] k, input logic [4:0] l);
        keyDown <= k;
        keyLvl <= l;
        tick(5);
    endtask
    task automatic completeRun;
        $display("compares %0d mismatches %0d", compares, numErrors);
        if (numErrors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            numErrors++;
            completeRun;
        end
    end

    initial
    begin
        tick(6);
        resetn <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            m = rows[i][2];
            p = rows[i][1];
            setup(m, {5{p}}, 5'h01);
            chk("pullUpEn", {31'h0, ~p}, {27'h0, pullUpEn});
            chk("pullDownEn", {31'h0, p}, {27'h0, pullDownEn});
            push(5'h01, {5{p}});
            chk("pendingFlag", 32'h1, {31'h0, pendingFlag});
            chk("irqRequest", 32'h1, {31'h0, irqRequest});
            vectorFetchAck <= 1'b1;
            tick(1);
            vectorFetchAck <= 1'b0;
            tick(2);
            chk("afterAck", {31'h0, rows[i][0]}, {31'h0, pendingFlag});
            push(5'h00, 5'h00);
            chk("released", 32'h0, {31'h0, pendingFlag});
            $display("row %0d done", i);
        end
        push(5'h01, 5'h1F);
        push(5'h00, 5'h00);
        chk("heldAfterRelease", 32'h1, {31'h0, pendingFlag});
        wr(SC, 32'h5);
        chk("ackAfterRelease", 32'h0, {31'h0, pendingFlag});
        $display("release then acknowledge test done");
        setup(1'b0, 5'h00, 5'h03);
        wr(SC, 32'h2);
        push(5'h02, 5'h00);
        chk("masked", 32'h0, {31'h0, irqRequest});
        rdchk("status", SC, 32'hA);
        wr(SC, 32'h6);
        chk("swAck", 32'h0, {31'h0, pendingFlag});
        push(5'h03, 5'h00);
        chk("heldOther", 32'h0, {31'h0, pendingFlag});
        push(5'h00, 5'h00);
        push(5'h01, 5'h00);
        chk("reArm", 32'h1, {31'h0, pendingFlag});
        $display("mask and edge test done");
        wr(kpil_pkg::OFS_PORT_DIR, 32'h4);
        wr(kpil_pkg::OFS_PORT_DATA, 32'h4);
        chk("pinOut", 32'h4, {27'h0, pinOut});
        chk("pinOe", 32'h4, {27'h0, pinOe});
        wr(kpil_pkg::OFS_PIN_ENABLE, 32'h7);
        chk("pinOeEn", 32'h0, {27'h0, pinOe});
        rdchk("unmapped", 8'h40, 32'h0);
        $display("port test done");
        setup(1'b1, 5'h01, 5'h01);
        push(5'h01, 5'h01);
        resetn <= 1'b0;
        tick(2);
        resetn <= 1'b1;
        tick(1);
        chk("rstPend", 32'h0, {31'h0, pendingFlag});
        rdchk("rstStatus", SC, 32'h0);
        rdchk("rstPol", kpil_pkg::OFS_PIN_POLARITY, 32'h0);
        push(5'h00, 5'h00);
        $display("reset test done");
        completeRun;
    end
endmodule // keypad_pin_interrupt_latch_test
